// >>> rtl/dvs_defines.svh
// Purpose: Constants of the DAC volume and soft-step playback path
// Assumes: APB word registers, byte address equals index times four
// Notes:   Header only, definitions and no logic
`ifndef DVS_DEFINES_SVH
`define DVS_DEFINES_SVH

// Register indices, byte address is index times four
`define DVS_IDX_LVOL   8'h00
`define DVS_IDX_RVOL   8'h01
`define DVS_IDX_MVOL   8'h02
`define DVS_IDX_CTRL   8'h03
`define DVS_IDX_STAT   8'h04
`define DVS_IDX_ISTAT  8'h05
`define DVS_IDX_IMASK  8'h06
`define DVS_IDX_BIAS   8'h6d

// Volume register fields
`define DVS_VOL_MUTE   7
`define DVS_CODE_MUTE  8'h80

// Control register fields
`define DVS_C_SLOW     0
`define DVS_C_NOSOFT   1
`define DVS_C_DEEMPH   2
`define DVS_C_EFFECT   3
`define DVS_C_PWR      4
`define DVS_C_PWRL     5
`define DVS_C_PWRR     6
`define DVS_C_CM_LO    8
`define DVS_CTRL_RST   10'h000

// Bias field and status bits
`define DVS_BIAS_LO    6
`define DVS_BIAS_RST   2'h0
`define DVS_S_DONE     0
`define DVS_S_PDN      1
`define DVS_S_FX       2

// Timing
`define DVS_GRP_DLY    21
`define DVS_MOD_RATIO  128
`define DVS_MOD_DIV    2
`define DVS_GAIN_STEPS 12

`endif

// >>> rtl/dvs_pkg.sv
// Purpose: Types of the DAC volume and soft-step playback path
// Assumes: Constants come from dvs_defines.svh
// Notes:   Types only
package dvs_pkg;

  // One stereo sample
  typedef struct packed {
    logic signed [15:0] l;
    logic signed [15:0] r;
  } dvs_smp_t;

  // Power and effects sequencer
  typedef enum logic [1:0] {
    ST_OFF,
    ST_RUN,
    ST_FXMUTE,
    ST_PDMUTE
  } dvs_state_t;

endpackage

// >>> rtl/dvs_top.sv
// Purpose: Digital volume, soft-step, sequencing and interpolation hold
// Assumes: CLK 10 MHz, host sample strobe and data arrive asynchronously
// Notes:   Modulator itself is outside; this feeds it held samples
`timescale 1ns/1ps
`include "dvs_defines.svh"

module dvs_top #(
  parameter int MOD_DIV = `DVS_MOD_DIV,
  parameter int GRP_DLY = `DVS_GRP_DLY
) (
  // Clock and reset
  input  wire logic            CLK,
  input  wire logic            RST_B,
  // APB slave
  input  wire logic            PSEL,
  input  wire logic            PENABLE,
  input  wire logic            PWRITE,
  input  wire logic [11:0]     PADDR,
  input  wire logic [31:0]     PWDATA,
  output logic      [31:0]     PRDATA,
  output logic                 PREADY,
  output logic                 PSLVERR,
  // Sample input from host pins
  input  wire logic            SMP_STB,
  input  wire dvs_pkg::dvs_smp_t SMP_IN,
  // Toward modulator and analog
  output dvs_pkg::dvs_smp_t    DAC_OUT,
  output logic                 MOD_STB,
  output logic                 DAC_PWR,
  output logic                 PWR_L,
  output logic                 PWR_R,
  output logic                 FX_DEEMPH,
  output logic                 FX_EFFECT,
  output logic [1:0]           BIAS_SEL,
  output logic [1:0]           CM_SEL,
  // Interrupt
  output logic                 IRQ
);

  // Attenuation mantissas for 0 .. 5.5 dB, each further 6 dB is a shift
  localparam logic [15:0] MANT [12] = '{16'hffff, 16'hf1ae, 16'he429,
    16'hd766, 16'hcb59, 16'hbff9, 16'hb53c, 16'hab19, 16'ha186,
    16'h987d, 16'h8ff5, 16'h87e8};

  logic [7:0]         lvol_r, rvol_r, lvol_nxt, rvol_nxt;
  logic [9:0]         ctrl_r, ctrl_nxt;
  logic [1:0]         bias_r, bias_nxt;
  logic [2:0]         imask_r, imask_nxt, istat_r, istat_nxt, ev;
  logic               pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [31:0]        prdata_r, prdata_nxt;
  logic               irq_r;
  logic [7:0]         idx;
  logic               hit, acc, wr, rd;
  logic [1:0]         fx_app_r, fx_app_nxt;
  dvs_pkg::dvs_state_t state_r, state_nxt;
  logic [7:0]         app_r [2];
  logic [7:0]         tgt [2];
  logic               all_mute, at_tgt, done_r, done_nxt, pwr_on_r;
  logic               stb_s1, stb_s2, stb_s3, new_smp, half_r, step;
  dvs_pkg::dvs_smp_t  smp_s1, smp_s2;
  dvs_pkg::dvs_smp_t  dly [GRP_DLY+1];
  logic [7:0]         div_r;
  logic               tick;
  logic signed [15:0] gout [2];
  dvs_pkg::dvs_smp_t  dac_r;
  logic               mod_r;

  // Address decode, word aligned index
  always_comb
  begin
    idx = PADDR[9:2];
    hit = (PADDR[11:10] == 2'h0) && (PADDR[1:0] == 2'h0) &&
          (idx <= `DVS_IDX_IMASK || idx == `DVS_IDX_BIAS);
  end

  // One wait state: PREADY rises in the second access cycle
  assign acc = PSEL & PENABLE;
  assign wr  = acc & pready_r & PWRITE & hit;
  assign rd  = acc & pready_r & ~PWRITE & hit;

  // Register file next values
  always_comb
  begin
    lvol_nxt   = lvol_r;
    rvol_nxt   = rvol_r;
    ctrl_nxt   = ctrl_r;
    bias_nxt   = bias_r;
    imask_nxt  = imask_r;
    pready_nxt = acc & ~pready_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    if (acc & ~pready_r)
    begin
      pslverr_nxt = ~hit;
      prdata_nxt  = 32'h0;
      if (hit & ~PWRITE)
      begin
        unique case (idx)
          `DVS_IDX_LVOL,
          `DVS_IDX_MVOL:  prdata_nxt[7:0] = lvol_r;
          `DVS_IDX_RVOL:  prdata_nxt[7:0] = rvol_r;
          `DVS_IDX_CTRL:  prdata_nxt[9:0] = ctrl_r;
          `DVS_IDX_STAT:  prdata_nxt[2:0] = {fx_app_r != 2'h0,
                                              state_r == dvs_pkg::ST_OFF,
                                              done_r};
          `DVS_IDX_ISTAT: prdata_nxt[2:0] = istat_r;
          `DVS_IDX_IMASK: prdata_nxt[2:0] = imask_r;
          `DVS_IDX_BIAS:  prdata_nxt[7:6] = bias_r;
          default:        prdata_nxt = 32'h0;
        endcase
      end
    end
    if (wr)
    begin
      unique case (idx)
        `DVS_IDX_LVOL:  lvol_nxt = PWDATA[7:0];
        `DVS_IDX_RVOL:  rvol_nxt = PWDATA[7:0];
        `DVS_IDX_MVOL:
        begin
          lvol_nxt = PWDATA[7:0];
          rvol_nxt = PWDATA[7:0];
        end
        `DVS_IDX_CTRL:  ctrl_nxt = PWDATA[9:0];
        `DVS_IDX_IMASK: imask_nxt = PWDATA[2:0];
        `DVS_IDX_BIAS:  bias_nxt = PWDATA[7:6];
        default:        ;
      endcase
    end
  end

  // Sticky events; a new event wins over the read clear
  // Only the reported bits clear, so an event after the capture survives
  always_comb
  begin
    istat_nxt = istat_r;
    if (rd && idx == `DVS_IDX_ISTAT)
      istat_nxt = istat_r & ~prdata_r[2:0];
    istat_nxt = istat_nxt | ev;
  end

  // Bus and register flops
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      lvol_r    <= 8'h00;
      rvol_r    <= 8'h00;
      ctrl_r    <= `DVS_CTRL_RST;
      bias_r    <= `DVS_BIAS_RST;   // Lowest bias current
      imask_r   <= 3'h0;
      istat_r   <= 3'h0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
      irq_r     <= 1'b0;
    end
    else
    begin
      lvol_r    <= lvol_nxt;
      rvol_r    <= rvol_nxt;
      ctrl_r    <= ctrl_nxt;
      bias_r    <= bias_nxt;
      imask_r   <= imask_nxt;
      istat_r   <= istat_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
      irq_r     <= |(istat_nxt & imask_nxt);
    end
  end

  // Pin synchronisers, edge detect compares the second and third stages
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      stb_s1 <= 1'b0;
      stb_s2 <= 1'b0;
      stb_s3 <= 1'b0;
      smp_s1 <= '0;
      smp_s2 <= '0;
    end
    else
    begin
      stb_s1 <= SMP_STB;
      stb_s2 <= stb_s1;
      stb_s3 <= stb_s2;
      smp_s1 <= SMP_IN;
      smp_s2 <= smp_s1;
    end
  end
  assign new_smp = stb_s2 & ~stb_s3;
  assign step    = new_smp & (~ctrl_r[`DVS_C_SLOW] | half_r);

  // Delay line, last entry is GRP_DLY samples old
  // One entry more than the delay, as entry 0 holds the newest sample
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      for (int i = 0; i <= GRP_DLY; i++)
        dly[i] <= '0;
    else if (new_smp)
    begin
      dly[0] <= smp_s2;
      for (int i = 1; i <= GRP_DLY; i++)
        dly[i] <= dly[i-1];
    end
  end

  // Sequencer: mute around power and effects changes
  always_comb
  begin
    state_nxt  = state_r;
    fx_app_nxt = fx_app_r;
    ev         = 3'h0;
    unique case (state_r)
      dvs_pkg::ST_OFF:
        if (ctrl_r[`DVS_C_PWR])
        begin
          state_nxt  = dvs_pkg::ST_RUN;            // Starts muted
          fx_app_nxt = ctrl_r[`DVS_C_EFFECT:`DVS_C_DEEMPH];
        end
      dvs_pkg::ST_RUN:
        if (!ctrl_r[`DVS_C_PWR])
          state_nxt = dvs_pkg::ST_PDMUTE;
        else if (ctrl_r[`DVS_C_EFFECT:`DVS_C_DEEMPH] != fx_app_r)
          state_nxt = dvs_pkg::ST_FXMUTE;
      dvs_pkg::ST_FXMUTE:
        if (all_mute)
        begin
          fx_app_nxt = ctrl_r[`DVS_C_EFFECT:`DVS_C_DEEMPH];
          state_nxt  = dvs_pkg::ST_RUN;
          ev[`DVS_S_FX] = 1'b1;
        end
      dvs_pkg::ST_PDMUTE:
        if (all_mute)
        begin
          state_nxt = dvs_pkg::ST_OFF;             // Flag after mute
          ev[`DVS_S_PDN] = 1'b1;
        end
    endcase
    done_nxt = (state_r == dvs_pkg::ST_RUN) && at_tgt;
    ev[`DVS_S_DONE] = done_nxt & ~done_r;
  end

  // Sequencer flops
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state_r  <= dvs_pkg::ST_OFF;
      fx_app_r <= 2'h0;
      done_r   <= 1'b0;
      half_r   <= 1'b0;
      pwr_on_r <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      fx_app_r <= fx_app_nxt;
      done_r   <= done_nxt;
      half_r   <= new_smp ? ~half_r : half_r;
      pwr_on_r <= state_nxt != dvs_pkg::ST_OFF;
    end
  end

  assign all_mute = app_r[0] == `DVS_CODE_MUTE && app_r[1] == `DVS_CODE_MUTE;
  assign at_tgt   = app_r[0] == tgt[0] && app_r[1] == tgt[1];

  // Modulator-rate enable, the hold upsamples each sample
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      div_r <= 8'h00;
    else
      div_r <= tick ? 8'h00 : div_r + 8'h01;
  end
  assign tick = div_r == 8'(MOD_DIV - 1);

  // Per channel target, soft-step and gain
  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    logic [7:0]         vol, app_nxt;
    logic [15:0]        mant;
    logic [3:0]         sh;
    logic signed [32:0] prod;
    logic signed [15:0] din;

    always_comb
    begin
      vol = (c == 0) ? lvol_r : rvol_r;
      if (state_r != dvs_pkg::ST_RUN || vol[`DVS_VOL_MUTE])
        tgt[c] = `DVS_CODE_MUTE;
      else
        tgt[c] = {1'b0, vol[6:0]};
      app_nxt = app_r[c];
      if (ctrl_r[`DVS_C_NOSOFT])
        app_nxt = tgt[c];
      else if (step && app_r[c] < tgt[c])
        app_nxt = app_r[c] + 8'h01;
      else if (step && app_r[c] > tgt[c])
        app_nxt = app_r[c] - 8'h01;
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
      if (!RST_B)
        app_r[c] <= `DVS_CODE_MUTE;
      else
        app_r[c] <= app_nxt;
    end

    // Gain is mantissa of code mod 12 shifted by code div 12
    always_comb
    begin
      din  = (c == 0) ? dly[GRP_DLY].l : dly[GRP_DLY].r;
      mant = MANT[4'(app_r[c][6:0] % 7'd12)];
      sh   = 4'(app_r[c][6:0] / 7'd12);
      prod = (din * $signed({1'b0, mant})) >>> (5'd16 + {1'b0, sh});
      gout[c] = app_r[c][7] ? 16'sh0000 : prod[15:0];
    end
  end

  // Output samples at modulator rate
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      dac_r <= '0;
      mod_r <= 1'b0;
    end
    else
    begin
      mod_r <= tick;
      if (tick)
      begin
        dac_r.l <= ctrl_r[`DVS_C_PWRL] ? gout[0] : 16'sh0000;
        dac_r.r <= ctrl_r[`DVS_C_PWRR] ? gout[1] : 16'sh0000;
      end
    end
  end

  assign PRDATA    = prdata_r;
  assign PREADY    = pready_r;
  assign PSLVERR   = pslverr_r;
  assign DAC_OUT   = dac_r;
  assign MOD_STB   = mod_r;
  assign DAC_PWR   = pwr_on_r;
  assign PWR_L     = ctrl_r[`DVS_C_PWRL];
  assign PWR_R     = ctrl_r[`DVS_C_PWRR];
  assign FX_DEEMPH = fx_app_r[0];
  assign FX_EFFECT = fx_app_r[1];
  assign BIAS_SEL  = bias_r;
  assign CM_SEL    = ctrl_r[`DVS_C_CM_LO+1:`DVS_C_CM_LO];
  assign IRQ       = irq_r;

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  sequence sq_mvol_wr;
    wr && idx == `DVS_IDX_MVOL;
  endsequence
  sequence sq_both_muted;
    all_mute && state_r == dvs_pkg::ST_FXMUTE;
  endsequence

  chk_master_both: assert property (sq_mvol_wr |=> lvol_r == rvol_r)
    else $error("master volume did not set both channels");
  chk_step_one: assert property (!ctrl_r[`DVS_C_NOSOFT] && !step
    |=> app_r[0] == $past(app_r[0]))
    else $error("gain moved without a sample step");
  chk_step_size: assert property (!ctrl_r[`DVS_C_NOSOFT] |=>
    (app_r[1] - $past(app_r[1]) <= 8'h01 ||
     $past(app_r[1]) - app_r[1] <= 8'h01))
    else $error("gain moved more than one step");
  chk_slow_skip: assert property (ctrl_r[`DVS_C_SLOW] && !half_r && new_smp
    |-> !step)
    else $error("slow mode stepped on odd sample");
  chk_jump_direct: assert property (ctrl_r[`DVS_C_NOSOFT] &&
    $stable(tgt[0]) |=> app_r[0] == $past(tgt[0]))
    else $error("no-soft mode did not jump");
  chk_done_flag: assert property (state_r == dvs_pkg::ST_RUN && at_tgt
    |=> done_r)
    else $error("done flag missing at target");
  chk_fx_muted: assert property ($changed(fx_app_r) &&
    $past(state_r) != dvs_pkg::ST_OFF |-> $past(all_mute))
    else $error("effects changed while not muted");
  chk_fx_resume: assert property (sq_both_muted |=>
    state_r == dvs_pkg::ST_RUN)
    else $error("no return to run after effects change");
  chk_pwrup_mute: assert property (state_r == dvs_pkg::ST_OFF
    |-> all_mute)
    else $error("gain not muted while off");
  chk_pwrdn_flag: assert property ($rose(state_r == dvs_pkg::ST_OFF)
    |-> $past(all_mute) && !pwr_on_r)
    else $error("powered down before mute");

endmodule // dvs_top

// >>> testbench/dvs_host_model.sv
// Purpose: Host sample source feeding the playback path
// Assumes: One stereo word per strobe, strobe every PER clocks
// Notes:   Data change at the strobe fall, far from its rising edge
`timescale 1ns/1ps

module dvs_host_model #(
  parameter int PER = 16 // Whole number of modulator periods
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Sample pins
  output logic              smp_stb,
  output dvs_pkg::dvs_smp_t smp_in
);
  int cnt_r;
  int seed = 32'h5ac2a743;

  // Strobe high half the period; new word only while it is low
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_r   <= 0;
      smp_stb <= 1'b0;
      smp_in  <= '0;
    end
    else
    begin
      cnt_r   <= (cnt_r == PER - 1) ? 0 : cnt_r + 1;
      smp_stb <= (cnt_r < PER / 2);
      if (cnt_r == PER / 2)
        smp_in <= $random(seed);
    end
  end
endmodule // dvs_host_model

// >>> testbench/dac_volume_softstep_path_tb.sv
// Purpose: Self-checking bench of the volume and soft-step path
// Assumes: APB master tasks, host model makes the samples
// Notes:   Ramp lengths are bounded, not matched to the exact cycle
`timescale 1ns/1ps

module dac_volume_softstep_path_tb;
  localparam int PER = 16;
  localparam int MD  = 2;
  localparam int GD  = 21;
  localparam logic [11:0] A_L = 12'h000, A_R = 12'h004, A_M = 12'h008;
  localparam logic [11:0] A_C = 12'h00c, A_S = 12'h010, A_I = 12'h014;
  localparam logic [11:0] A_K = 12'h018, A_B = 12'h1b4;

  logic              clk;
  logic              rst_b;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [11:0]       paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              smp_stb;
  dvs_pkg::dvs_smp_t smp_in;
  dvs_pkg::dvs_smp_t dac_out;
  logic              mod_stb;
  logic              dac_pwr;
  logic              pwr_l;
  logic              pwr_r;
  logic              fx_deemph;
  logic              fx_effect;
  logic [1:0]        bias_sel;
  logic [1:0]        cm_sel;
  logic              irq;
  int                mismatches;
  int                compares;
  int                seed;
  int                n;
  logic [31:0]       q;
  logic [31:0]       c;
  logic              e;
  logic              stb_q = 1'b0;
  dvs_pkg::dvs_smp_t hist [GD+1];

  dvs_top #(.MOD_DIV(MD), .GRP_DLY(GD)) dvs_top_inst (
    .CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SMP_STB(smp_stb),
    .SMP_IN(smp_in), .DAC_OUT(dac_out), .MOD_STB(mod_stb),
    .DAC_PWR(dac_pwr), .PWR_L(pwr_l), .PWR_R(pwr_r),
    .FX_DEEMPH(fx_deemph), .FX_EFFECT(fx_effect), .BIAS_SEL(bias_sel),
    .CM_SEL(cm_sel), .IRQ(irq)
  );

  dvs_host_model #(.PER(PER)) dvs_host_model_inst (
    .clk(clk), .rst_b(rst_b), .smp_stb(smp_stb), .smp_in(smp_in)
  );

  // Record each host sample as its strobe rises, newest first
  always @(posedge clk)
  begin
    stb_q <= smp_stb;
    if (smp_stb === 1'b1 && stb_q === 1'b0)
    begin
      hist[0] <= smp_in;
      for (int i = 1; i <= GD; i++)
        hist[i] <= hist[i-1];
    end
  end

  // Clock never stops, also after power-down completes
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task stop_test;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask

  // Unity gain may lose one LSB in the product; unknowns never pass
  function automatic logic near(input logic signed [15:0] a,
                                input logic signed [15:0] b);
    logic [16:0] d;
    d = {a[15], a} - {b[15], b};
    return (d == 17'h0) || (d == 17'h1) || (d == 17'h1ffff);
  endfunction

  // One APB transfer; request held until pready is sampled high
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic er);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      mismatches++;
      stop_test();
    end
    r = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        er;
    xfer(1'b1, a, d, r, er);
    repeat (2) @(posedge clk);
  endtask

  task rd(input logic [11:0] a, output logic [31:0] r);
    logic er;
    xfer(1'b0, a, 32'h0, r, er);
  endtask

  // Poll status until masked bits match, bounded
  task poll(input logic [31:0] m, input logic [31:0] v, input int lim);
    logic [31:0] r;
    int          k;
    k = 0;
    r = ~v;
    while (((r & m) !== v) && k < lim)
    begin
      rd(A_S, r);
      k++;
    end
    chk(r & m, v);
    if ((r & m) !== v)
      stop_test();
  endtask

  task smp(input int k);
    repeat (k * PER + 4) @(posedge clk);
  endtask

  // Hang guard
  initial
  begin
    repeat (90000) @(posedge clk);
    mismatches++;
    stop_test();
  end

  initial
  begin
    rst_b   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    mismatches = 0;
    compares = 0;
    seed = 32'h5ac2a743;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    // Reset values, unmapped place
    rd(A_S, q);
    chk(q, 32'h2);
    rd(A_B, q);
    chk(q, 32'h0);
    xfer(1'b0, 12'h020, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    $display("test reset finished");
    // Bias and common mode, volume range while off
    wr(A_B, 32'h000000c0);
    chk({30'h0, bias_sel}, 32'h3);
    for (int i = 0; i < 4; i++)
    begin
      wr(A_C, i << 8);
      chk({30'h0, cm_sel}, i);
    end
    wr(A_L, 32'h7f);
    wr(A_R, 32'h01);
    rd(A_L, q);
    chk(q, 32'h7f);
    rd(A_R, q);
    chk(q, 32'h01);
    $display("test config finished");
    // Power-up from mute through the master volume
    c = $random(seed) & 32'h0000000f;
    wr(A_K, 32'h7);
    wr(A_M, c);
    rd(A_R, q);
    chk(q, c);
    wr(A_C, 32'h70);
    chk({29'h0, dac_pwr, pwr_l, pwr_r}, 32'h7);
    chk(dac_out, 32'h0);
    rd(A_S, q);
    chk(q & 32'h3, 32'h0);
    poll(32'h1, 32'h1, 700);
    chk({31'h0, irq}, 32'h1);
    rd(A_I, q);
    chk(q & 32'h1, 32'h1);
    n = 0;
    while (mod_stb !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    n = 1;
    while (mod_stb !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    chk(n, MD);
    $display("test power-up finished");
    // Ten-step ramps, normal then slow
    for (int s = 0; s < 2; s++)
    begin
      wr(A_C, 32'h70 | s);
      c = (s == 0) ? c + 10 : c - 10;
      wr(A_L, c);
      rd(A_S, q);
      chk(q & 32'h1, 32'h0);
      smp(8 << s);
      rd(A_S, q);
      chk(q & 32'h1, 32'h0);
      poll(32'h1, 32'h1, 15 << s);
    end
    // Soft-step off: jump at once
    wr(A_C, 32'h72);
    wr(A_L, 32'h7f);
    rd(A_S, q);
    chk(q & 32'h1, 32'h1);
    // Unity gain: output is the sample sent GD samples before
    wr(A_M, 32'h0);
    n = 0;
    while (!(smp_stb === 1'b1 && stb_q === 1'b0) && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 40)
      mismatches++;
    repeat (8) @(posedge clk);
    chk({31'h0, near(dac_out.l, hist[GD].l)}, 32'h1);
    chk({31'h0, near(dac_out.r, hist[GD].r)}, 32'h1);
    $display("test ramp finished");
    // Mute bit ramps like a gain target
    wr(A_C, 32'h70);
    wr(A_L, 32'h80 | c);
    poll(32'h1, 32'h1, 700);
    smp(24);
    chk(dac_out[31:16], 32'h0);
    wr(A_L, c);
    poll(32'h1, 32'h1, 700);
    $display("test mute finished");
    // Effects switch: mute, apply, unmute
    rd(A_I, q);
    wr(A_C, 32'h7c);
    chk({30'h0, fx_deemph, fx_effect}, 32'h0);
    poll(32'h4, 32'h4, 700);
    chk({30'h0, fx_deemph, fx_effect}, 32'h3);
    chk({31'h0, irq}, 32'h1);
    rd(A_I, q);
    chk(q & 32'h4, 32'h4);
    poll(32'h1, 32'h1, 700);
    $display("test effects finished");
    // Power-down with interrupt masked
    wr(A_K, 32'h0);
    rd(A_I, q);
    wr(A_C, 32'h0c);
    rd(A_S, q);
    chk(q & 32'h2, 32'h0);
    chk({31'h0, dac_pwr}, 32'h1);
    poll(32'h2, 32'h2, 700);
    chk({31'h0, dac_pwr}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rd(A_I, q);
    chk(q & 32'h2, 32'h2);
    $display("test power-down finished");
    stop_test();
  end
endmodule // dac_volume_softstep_path_tb
